// *** include/pump_seq_pkg.sv ***
// package: constants, states and carrier structs for the pump run sequencer
// Functional notes
// - start begins acceleration, backing pump relay closes
// - start delay: start lamp flashes, then steady
// - acceleration: at-speed lamp flashes, bar shows speed
// - at 95 percent: at-speed state, lamps update
// - at-speed state: bar graph shows motor current
// - minimum reached, no 95 percent in 8 min: overload
// - heating key toggles heater; bake only at speed
// - heating lamp flashes accelerating, steady at speed
// - over temperature: reduce speed, overload lamp on
// - below 95 percent: bar shows speed, lamp flashes
// - below minimum: motor off, fault lamp on
// - stop: drive and heater off, brake, pump off
// - braking: stop lamp, at-speed flashes, speed bar
// - vent valve controlled automatically when stopped
// - mains loss: generator mode keeps bearings powered
// - standstill after stop: start, stop, at-speed off
// - fault: brake, fault lamp steady, code segment flashes
// - fault reset by stop only at standstill, cleared
// - fault code 1 is motor line fault
// - low-active remote stop dominates start
// - fault relay changes state only in fault states
package pump_seq_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int BAR_SEGS = 10;
   localparam int SPEED_W = 16;
   localparam int CUR_W = 16;
   localparam int CODE_W = 4;
   // configuration constants, in speed and current units, seconds and milliseconds
   localparam logic [SPEED_W-1:0] TARGET_SPEED = 16'h0258;
   localparam logic [SPEED_W-1:0] AT_SPEED_LEVEL = 16'(600 * 95 / 100);
   localparam logic [SPEED_W-1:0] MIN_SPEED = 16'h00F0;
   localparam logic [SPEED_W-1:0] STANDSTILL_SPEED = 16'h0002;
   localparam logic [SPEED_W-1:0] SPEED_STEP = 16'(600 / 10);
   localparam logic [CUR_W-1:0] MAX_CURRENT = 16'h03E8;
   localparam logic [CUR_W-1:0] CURRENT_STEP = 16'(1000 / 10);
   localparam int START_DELAY_S = 60;
   localparam int ACCEL_LIMIT_S = 8 * 60;
   localparam int FLASH_HALF_MS = 250;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int FLASH_HALF_TICKS = FLASH_HALF_MS / TICK_MS;
   localparam int START_DELAY_TICKS = START_DELAY_S * 1000 / TICK_MS;
   localparam int ACCEL_LIMIT_TICKS = ACCEL_LIMIT_S * 1000 / TICK_MS;
   localparam int TIMER_W = 20;
   localparam logic [CODE_W-1:0] FAULT_NONE = 4'h0;
   localparam logic [CODE_W-1:0] FAULT_LINE = 4'h1;
   localparam logic [CODE_W-1:0] FAULT_UNSUPPORTED = 4'h2;
   localparam logic [CODE_W-1:0] FAULT_SPEED = 4'h4;
   localparam logic [CODE_W-1:0] FAULT_CONV_TEMP = 4'h5;
   localparam logic [CODE_W-1:0] FAULT_PUMP_TEMP = 4'h6;
   localparam logic [CODE_W-1:0] FAULT_SELF_TEST = 4'h7;
   localparam logic [CODE_W-1:0] FAULT_BEARING = 4'h8;

   typedef enum logic [3:0] {
      ST_STANDSTILL = 4'h0,
      ST_DELAY = 4'h1,
      ST_ACCEL = 4'h2,
      ST_AT_SPEED = 4'h3,
      ST_OVERLOAD = 4'h4,
      ST_BRAKING = 4'h5,
      ST_FAULT_RUN = 4'h6,
      ST_FAULT_STILL = 4'h7
   } run_state_t;

   typedef struct packed {
      logic start_key;
      logic stop_key;
      logic heat_key;
      logic remote_en;
      logic remote_start;
      logic remote_stop_n;
      logic remote_heat;
   } operator_in_t;

   typedef struct packed {
      logic line_fault;
      logic unsupported;
      logic conv_overtemp;
      logic pump_overtemp;
      logic self_test;
      logic bearing;
      logic mains_ok;
   } sense_in_t;

   typedef struct packed {
      logic start_lamp;
      logic stop_lamp;
      logic at_speed_lamp;
      logic overload_lamp;
      logic fault_lamp;
      logic heat_lamp;
      logic line_attached_warning;
      logic [BAR_SEGS-1:0] bar;
   } lamps_t;

   typedef struct packed {
      logic motor_drive;
      logic brake;
      logic reduce_speed;
      logic generator_mode;
      logic bearing_power;
      logic backing_pump_relay;
      logic vent_valve;
      logic heater;
      logic fault_relay;
      logic accel_relay;
      logic normal_relay;
   } actuators_t;
endpackage

// *** rtl/bar_scale.sv ***
// registered thermometer bar graph from a scaled value
`timescale 1ns/1ps
module bar_scale
   import pump_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [SPEED_W-1:0] value,
   input wire logic [SPEED_W-1:0] step,
   output logic [BAR_SEGS-1:0] bar
);
   logic [BAR_SEGS-1:0] lit;

   // segment i lights once value reaches (i+1) steps, bottom first
   genvar i;
   generate
      for (i = 0; i < BAR_SEGS; i++) begin : g_seg
         assign lit[i] = ({16'h0000, value} >= 32'(step) * 32'(i + 1));
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bar <= '0;
      end else begin
         bar <= lit;
      end
   end
endmodule

// *** rtl/pulse_tick.sv ***
// tick and flash enable generator
`timescale 1ns/1ps
module pulse_tick
   import pump_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   output logic tick,
   output logic flash
);
   logic [$clog2(TICK_CYCLES)-1:0] div_reg;
   logic [$clog2(FLASH_HALF_TICKS)-1:0] half_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         div_reg <= '0;
         tick <= 1'b0;
      end else if (div_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
         div_reg <= '0;
         tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 1'b1;
         tick <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         half_reg <= '0;
         flash <= 1'b0;
      end else if (tick) begin
         if (half_reg == ($clog2(FLASH_HALF_TICKS))'(FLASH_HALF_TICKS - 1)) begin
            half_reg <= '0;
            flash <= ~flash;
         end else begin
            half_reg <= half_reg + 1'b1;
         end
      end
   end
endmodule

// *** rtl/pump_run_sequencer.sv ***
// pump run sequencer: start, run, stop, fault and mains-loss handling
`timescale 1ns/1ps
module pump_run_sequencer
   import pump_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic delay_enable,
   input wire logic vent_fitted,
   input wire operator_in_t op_in,
   input wire sense_in_t sense_in,
   input wire logic [SPEED_W-1:0] speed,
   input wire logic [CUR_W-1:0] current,
   output lamps_t lamps,
   output actuators_t act,
   output logic [CODE_W-1:0] fault_code
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   operator_in_t op_meta_reg, op_sync_reg, op_prev_reg;
   sense_in_t sn_meta_reg, sn_sync_reg;
   logic delay_meta_reg, delay_sync_reg, vent_meta_reg, vent_sync_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         op_meta_reg <= '0;
         op_sync_reg <= '0;
         op_prev_reg <= '0;
         sn_meta_reg <= '0;
         sn_sync_reg <= '0;
         delay_meta_reg <= 1'b0;
         delay_sync_reg <= 1'b0;
         vent_meta_reg <= 1'b0;
         vent_sync_reg <= 1'b0;
      end else begin
         op_meta_reg <= op_in;
         op_sync_reg <= op_meta_reg;
         op_prev_reg <= op_sync_reg;
         sn_meta_reg <= sense_in;
         sn_sync_reg <= sn_meta_reg;
         delay_meta_reg <= delay_enable;
         delay_sync_reg <= delay_meta_reg;
         vent_meta_reg <= vent_fitted;
         vent_sync_reg <= vent_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // helper decodes
   // ---------------------------------------------------------------
   // rising edge of a synchronised key; one pulse per press
   function automatic logic key_edge(input logic now_v, input logic prev_v);
      return now_v & ~prev_v;
   endfunction

   // states in which the backing pump runs and the vent stays shut
   function automatic logic pump_phase(input run_state_t st);
      return st inside {ST_DELAY, ST_ACCEL, ST_AT_SPEED, ST_OVERLOAD};
   endfunction

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   logic start_cmd, stop_cmd, heat_toggle, stop_level;
   logic tick, flash;

   // remote stop is a level: while low with remote_en set it blocks start and forces stop
   always_comb begin
      stop_level = op_sync_reg.remote_en & ~op_sync_reg.remote_stop_n;
      if (op_sync_reg.remote_en) begin
         start_cmd = op_sync_reg.remote_start & ~stop_level;
         stop_cmd = stop_level | (op_prev_reg.remote_stop_n & ~op_sync_reg.remote_stop_n);
         heat_toggle = op_sync_reg.remote_heat ^ op_prev_reg.remote_heat;
      end else begin
         start_cmd = key_edge(op_sync_reg.start_key, op_prev_reg.start_key);
         stop_cmd = key_edge(op_sync_reg.stop_key, op_prev_reg.stop_key);
         heat_toggle = key_edge(op_sync_reg.heat_key, op_prev_reg.heat_key);
      end
   end

   pulse_tick u_tick (
      .clk_sys(clk_sys),
      .srst(srst),
      .tick(tick),
      .flash(flash)
   );

   // ---------------------------------------------------------------
   // speed and fault classification
   // ---------------------------------------------------------------
   logic at_speed, above_min, standstill, overtemp, hard_fault;
   logic [CODE_W-1:0] hard_code;

   always_comb begin
      at_speed = speed >= AT_SPEED_LEVEL;
      above_min = speed >= MIN_SPEED;
      standstill = speed <= STANDSTILL_SPEED;
      // overtemp is no hard fault: it slows the rotor, moves the at-speed state into overload and blocks a fault reset
      overtemp = sn_sync_reg.conv_overtemp | sn_sync_reg.pump_overtemp;
      hard_fault = 1'b1;
      if (sn_sync_reg.line_fault) begin
         hard_code = FAULT_LINE;
      end else if (sn_sync_reg.unsupported) begin
         hard_code = FAULT_UNSUPPORTED;
      end else if (sn_sync_reg.self_test) begin
         hard_code = FAULT_SELF_TEST;
      end else if (sn_sync_reg.bearing) begin
         hard_code = FAULT_BEARING;
      end else begin
         hard_code = FAULT_NONE;
         hard_fault = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // run state machine and its timer
   // ---------------------------------------------------------------
   run_state_t state_reg, state_next;
   logic [TIMER_W-1:0] timer_reg;
   logic [CODE_W-1:0] code_reg, code_next;
   logic speed_seen_min_reg;

   always_comb begin
      state_next = state_reg;
      code_next = code_reg;
      case (state_reg)
         ST_STANDSTILL: begin
            if (hard_fault) begin
               state_next = ST_FAULT_STILL;
               code_next = hard_code;
            end else if (start_cmd) begin
               state_next = delay_sync_reg ? ST_DELAY : ST_ACCEL;
            end
         end
         ST_DELAY: begin
            if (stop_cmd) begin
               state_next = ST_STANDSTILL;
            end else if (timer_reg == TIMER_W'(START_DELAY_TICKS)) begin
               state_next = ST_ACCEL;
            end
         end
         ST_ACCEL: begin
            if (stop_cmd) begin
               state_next = ST_BRAKING;
            end else if (at_speed) begin
               state_next = ST_AT_SPEED;
            end else if (timer_reg == TIMER_W'(ACCEL_LIMIT_TICKS)) begin
               if (speed_seen_min_reg) begin
                  state_next = ST_OVERLOAD;
               end else begin
                  state_next = ST_FAULT_RUN;
                  code_next = FAULT_SPEED;
               end
            end
         end
         ST_AT_SPEED, ST_OVERLOAD: begin
            if (stop_cmd) begin
               state_next = ST_BRAKING;
            end else if (~above_min) begin
               state_next = ST_FAULT_RUN;
               code_next = FAULT_SPEED;
            end else if (at_speed & ~overtemp) begin
               state_next = ST_AT_SPEED;
            end else if (state_reg == ST_AT_SPEED & overtemp) begin
               state_next = ST_OVERLOAD;
            end
         end
         ST_BRAKING: begin
            if (standstill) begin
               state_next = ST_STANDSTILL;
            end
         end
         ST_FAULT_RUN: begin
            if (standstill) begin
               state_next = ST_FAULT_STILL;
            end
         end
         ST_FAULT_STILL: begin
            if (stop_cmd & ~hard_fault & ~overtemp & standstill) begin
               state_next = ST_STANDSTILL;
               code_next = FAULT_NONE;
            end
         end
         default: begin
            state_next = ST_STANDSTILL;
         end
      endcase
      // any hard fault while turning brakes into the fault state
      if (hard_fault & (state_reg inside {ST_DELAY, ST_ACCEL, ST_AT_SPEED, ST_OVERLOAD, ST_BRAKING})) begin
         state_next = ST_FAULT_RUN;
         code_next = hard_code;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= ST_STANDSTILL;
         code_reg <= FAULT_NONE;
      end else begin
         state_reg <= state_next;
         code_reg <= code_next;
      end
   end

   // timer restarts on every state change, counts ms ticks
   always_ff @(posedge clk_sys) begin
      if (srst || state_next != state_reg) begin
         timer_reg <= '0;
      end else if (tick && timer_reg != '1) begin
         timer_reg <= timer_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || state_reg != ST_ACCEL) begin
         speed_seen_min_reg <= 1'b0;
      end else if (above_min) begin
         speed_seen_min_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // heating preselection
   // ---------------------------------------------------------------
   logic heat_sel_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         heat_sel_reg <= 1'b0;
      end else if (state_next == ST_BRAKING || state_next == ST_FAULT_RUN) begin
         heat_sel_reg <= 1'b0;
      end else if (heat_toggle) begin
         heat_sel_reg <= ~heat_sel_reg;
      end
   end

   // ---------------------------------------------------------------
   // bar graph sources
   // ---------------------------------------------------------------
   logic [BAR_SEGS-1:0] speed_bar, current_bar, code_bar;

   bar_scale u_speed_bar (
      .clk_sys(clk_sys),
      .srst(srst),
      .value(speed),
      .step(SPEED_STEP),
      .bar(speed_bar)
   );

   bar_scale u_current_bar (
      .clk_sys(clk_sys),
      .srst(srst),
      .value(current),
      .step(CURRENT_STEP),
      .bar(current_bar)
   );

   // code 1 maps to the bottom segment, dark in the off half of the flash
   always_comb begin
      code_bar = '0;
      if (code_reg != FAULT_NONE) begin
         code_bar = BAR_SEGS'(1) << (code_reg - 1'b1);
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   logic running, fault_st, mains_lost;

   always_comb begin
      running = state_reg inside {ST_ACCEL, ST_AT_SPEED, ST_OVERLOAD};
      fault_st = state_reg inside {ST_FAULT_RUN, ST_FAULT_STILL};
      mains_lost = ~sn_sync_reg.mains_ok;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lamps <= '0;
      end else begin
         lamps.start_lamp <= (state_reg == ST_DELAY) ? flash : running;
         lamps.stop_lamp <= state_reg == ST_BRAKING;
         // over temperature lights overload even before the overload state
         lamps.overload_lamp <= state_reg == ST_OVERLOAD || (running && overtemp);
         lamps.fault_lamp <= fault_st;
         lamps.line_attached_warning <= ~standstill;
         // start lamp goes dark once at speed
         if (state_reg == ST_AT_SPEED || state_reg == ST_OVERLOAD) begin
            lamps.start_lamp <= 1'b0;
         end
         case (state_reg)
            ST_ACCEL, ST_BRAKING: begin
               lamps.at_speed_lamp <= flash;
               lamps.bar <= speed_bar;
            end
            ST_AT_SPEED: begin
               lamps.at_speed_lamp <= at_speed ? 1'b1 : flash;
               lamps.bar <= at_speed ? current_bar : speed_bar;
            end
            ST_OVERLOAD: begin
               lamps.at_speed_lamp <= at_speed ? 1'b1 : flash;
               lamps.bar <= speed_bar;
            end
            ST_FAULT_RUN, ST_FAULT_STILL: begin
               lamps.at_speed_lamp <= 1'b0;
               lamps.bar <= flash ? code_bar : '0;
            end
            default: begin
               lamps.at_speed_lamp <= 1'b0;
               lamps.bar <= '0;
            end
         endcase
         if (state_reg == ST_ACCEL || state_reg == ST_DELAY) begin
            lamps.heat_lamp <= heat_sel_reg & flash;
         end else begin
            lamps.heat_lamp <= heat_sel_reg;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         act <= '0;
         act.fault_relay <= 1'b1;
         fault_code <= FAULT_NONE;
      end else begin
         fault_code <= code_reg;
         act.motor_drive <= running & ~mains_lost;
         act.brake <= (state_reg == ST_BRAKING || state_reg == ST_FAULT_RUN) & ~mains_lost;
         act.reduce_speed <= running & overtemp;
         act.generator_mode <= mains_lost & ~standstill;
         act.bearing_power <= 1'b1;
         act.backing_pump_relay <= pump_phase(state_reg);
         act.vent_valve <= vent_sync_reg & ~pump_phase(state_reg);
         act.heater <= heat_sel_reg & (state_reg == ST_AT_SPEED);
         act.fault_relay <= ~fault_st;
         act.accel_relay <= state_reg == ST_DELAY || state_reg == ST_ACCEL;
         act.normal_relay <= state_reg == ST_AT_SPEED || state_reg == ST_OVERLOAD;
      end
   end
endmodule

// *** verification/pump_model.sv ***
// behavioural pump rotor: speed follows drive only; the brake output is not modelled
`timescale 1ns/1ps
module pump_model
   import pump_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire actuators_t act,
   input wire logic force_en,
   input wire logic [SPEED_W-1:0] force_speed,
   input wire logic [CUR_W-1:0] cur_set,
   output logic [SPEED_W-1:0] speed,
   output logic [CUR_W-1:0] current
);
   // reduced drive holds speed; no drive runs down unless force_en forces the speed
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         speed <= 16'h0000;
      end else if (force_en) begin
         speed <= force_speed;
      end else if (act.motor_drive && act.reduce_speed) begin
         speed <= speed;
      end else if (act.motor_drive) begin
         speed <= (speed >= TARGET_SPEED - 16'h0008) ? TARGET_SPEED : speed + 16'h0008;
      end else begin
         speed <= (speed > 16'h0008) ? speed - 16'h0008 : 16'h0000;
      end
   end
   assign current = act.motor_drive ? cur_set : 16'h0000;
endmodule

// *** verification/pump_seq_checker.sv ***
// checker: concurrent properties on the sequencer top ports
`timescale 1ns/1ps
module pump_seq_checker
   import pump_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic delay_enable,
   input wire logic vent_fitted,
   input wire operator_in_t op_in,
   input wire sense_in_t sense_in,
   input wire logic [SPEED_W-1:0] speed,
   input wire logic [CUR_W-1:0] current,
   input wire lamps_t lamps,
   input wire actuators_t act,
   input wire logic [CODE_W-1:0] fault_code
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   run_pump_a: assert property (act.motor_drive |-> act.backing_pump_relay)
      else $error("drive on without backing pump");
   start_lamp_a: assert property (lamps.start_lamp |-> act.backing_pump_relay)
      else $error("start lamp without backing pump");
   at_speed_a: assert property (act.normal_relay |-> !lamps.start_lamp && !act.accel_relay)
      else $error("start lamp lit at speed");
   heat_gate_a: assert property (act.heater |-> lamps.heat_lamp && act.normal_relay)
      else $error("heater outside at-speed state");
   brake_off_a: assert property (act.brake |-> !act.motor_drive && !act.heater)
      else $error("drive or heater during braking");
   vent_stop_a: assert property (act.vent_valve |-> !act.motor_drive && !act.backing_pump_relay)
      else $error("vent open while driving");
   mains_gen_a: assert property (act.generator_mode |-> act.bearing_power && !act.motor_drive)
      else $error("generator mode without bearing power");
   fault_lamp_a: assert property (!act.fault_relay |-> lamps.fault_lamp && !act.motor_drive)
      else $error("fault state without fault lamp");
   fault_bar_a: assert property ((!act.fault_relay)[*3]
      |-> (lamps.bar & ~(10'h001 << (fault_code - 4'h1))) == 10'h000)
      else $error("bar shows more than the fault segment");
   fault_relay_a: assert property (!act.fault_relay |-> fault_code != FAULT_NONE)
      else $error("fault relay without fault code");
   fault_reset_a: assert property ($rose(act.fault_relay) |-> speed <= STANDSTILL_SPEED)
      else $error("fault reset while rotor turning");
   remote_stop_a: assert property ((op_in.remote_en && !op_in.remote_stop_n)[*8]
      |-> !$rose(act.motor_drive))
      else $error("start taken under remote stop");
endmodule

// *** verification/tb_top.sv ***
// testbench: start, run, stop, fault and mains-loss sequences
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
`define WAITC(c, lim, nm) begin int k; k = 0; while (!(c) && k < lim) begin step(1); k++; end \
   if (!(c)) begin n_fail++; $display("[ERR] %s exp=1 got=0", nm); tally_and_finish(); end end
module tb_top;
   import pump_seq_pkg::*;
   logic clk_sys, srst, delay_enable, vent_fitted, force_en;
   operator_in_t op_in;
   sense_in_t sense_in;
   logic [SPEED_W-1:0] speed, force_speed;
   logic [CUR_W-1:0] current, cur_set;
   lamps_t lamps;
   actuators_t act;
   logic [CODE_W-1:0] fault_code;
   int n_fail, n_compared, rs;

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   pump_run_sequencer DUT (.clk_sys(clk_sys), .srst(srst), .delay_enable(delay_enable),
      .vent_fitted(vent_fitted), .op_in(op_in), .sense_in(sense_in), .speed(speed),
      .current(current), .lamps(lamps), .act(act), .fault_code(fault_code));
   pump_model u_pump (.clk_sys(clk_sys), .srst(srst), .act(act), .force_en(force_en),
      .force_speed(force_speed), .cur_set(cur_set), .speed(speed), .current(current));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // thermometer of whole steps, bottom segment first
   function automatic logic [BAR_SEGS-1:0] therm(input int v, input int st);
      int n;
      n = v / st;
      if (n > BAR_SEGS) n = BAR_SEGS;
      return (10'h001 << n) - 10'h001;
   endfunction
   task automatic press(input int key);
      if (key == 0) op_in.start_key = 1'b1; else if (key == 1) op_in.stop_key = 1'b1;
      else op_in.heat_key = 1'b1;
      step(3);
      op_in.start_key = 1'b0;
      op_in.stop_key = 1'b0;
      op_in.heat_key = 1'b0;
      step(6);
   endtask
   task automatic tally_and_finish();
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      srst = 1'b1; delay_enable = 1'b0; vent_fitted = 1'b1; force_en = 1'b0;
      op_in = '0; op_in.remote_stop_n = 1'b1;
      sense_in = '0; sense_in.mains_ok = 1'b1;
      force_speed = 16'h0000; n_fail = 0; n_compared = 0;
      rs = $urandom(32'hbac0);
      cur_set = 16'(100 * (1 + $urandom % 9));
      step(12);
      srst = 1'b0;
      step(4);
      `CHK("fault_relay", 1'b1, act.fault_relay)
      `CHK("lamps", 17'h0_0000, lamps)
      // remote stop held low dominates a remote start
      op_in.remote_en = 1'b1; op_in.remote_stop_n = 1'b0; op_in.remote_start = 1'b1;
      step(20);
      `CHK("drive_remote", 1'b0, act.motor_drive)
      op_in.remote_start = 1'b0; op_in.remote_en = 1'b0; op_in.remote_stop_n = 1'b1;
      step(6);
      press(0);
      `WAITC(act.motor_drive === 1'b1, 20, "start")
      `CHK("backing", 1'b1, act.backing_pump_relay)
      `CHK("start_lamp", 1'b1, lamps.start_lamp)
      `CHK("accel_rly", 1'b1, act.accel_relay)
      `WAITC(act.normal_relay === 1'b1, 300, "at_speed")
      step(3);
      `CHK("start_off", 1'b0, lamps.start_lamp)
      `CHK("speed_lamp", 1'b1, lamps.at_speed_lamp)
      `CHK("bar_cur", therm(cur_set, 100), lamps.bar)
      press(2);
      `CHK("heater_on", 1'b1, act.heater)
      `CHK("heat_lamp", 1'b1, lamps.heat_lamp)
      press(2);
      `CHK("heater_off", 1'b0, act.heater)
      sense_in.pump_overtemp = 1'b1;
      step(6);
      `CHK("reduce", 1'b1, act.reduce_speed)
      `CHK("overload", 1'b1, lamps.overload_lamp)
      sense_in.pump_overtemp = 1'b0;
      `WAITC(lamps.overload_lamp === 1'b0 && act.normal_relay === 1'b1, 100, "recover")
      // speed sagging between minimum and the at-speed level
      rs = 250 + $urandom % 300;
      force_speed = 16'(rs); force_en = 1'b1;
      step(8);
      `CHK("bar_speed", therm(rs, 60), lamps.bar)
      force_en = 1'b0;
      `WAITC(lamps.bar === therm(cur_set, 100), 300, "bar_back")
      press(1);
      `WAITC(act.brake === 1'b1, 20, "brake")
      `CHK("drive_off", 1'b0, act.motor_drive)
      `CHK("backing_off", 1'b0, act.backing_pump_relay)
      `CHK("stop_lamp", 1'b1, lamps.stop_lamp)
      `CHK("warn_on", 1'b1, lamps.line_attached_warning)
      `WAITC(speed <= STANDSTILL_SPEED && lamps.stop_lamp === 1'b0, 300, "standstill")
      step(3);
      `CHK("lamps_off", 3'b000, {lamps.start_lamp, lamps.at_speed_lamp, act.brake})
      `CHK("vent", 1'b1, act.vent_valve)
      `CHK("warn_off", 1'b0, lamps.line_attached_warning)
      // line fault while running, reset refused until the cause clears
      press(0);
      `WAITC(act.normal_relay === 1'b1, 300, "restart")
      sense_in.line_fault = 1'b1;
      `WAITC(act.fault_relay === 1'b0, 20, "fault")
      `CHK("fault_brake", 1'b1, act.brake)
      `CHK("fault_lamp", 1'b1, lamps.fault_lamp)
      `CHK("code_line", FAULT_LINE, fault_code)
      `WAITC(speed === 16'h0000, 300, "fault_still")
      press(1);
      `CHK("reset_refused", 1'b0, act.fault_relay)
      sense_in.line_fault = 1'b0;
      step(6);
      press(1);
      `WAITC(act.fault_relay === 1'b1, 20, "fault_reset")
      `CHK("code_clear", FAULT_NONE, fault_code)
      // speed collapsing below minimum
      press(0);
      `WAITC(act.normal_relay === 1'b1, 300, "run3")
      force_speed = 16'h0064; force_en = 1'b1;
      `WAITC(lamps.fault_lamp === 1'b1, 20, "below_min")
      `CHK("min_drive", 1'b0, act.motor_drive)
      `CHK("code_speed", FAULT_SPEED, fault_code)
      force_en = 1'b0;
      `WAITC(speed === 16'h0000, 300, "min_still")
      step(6);
      press(1);
      `WAITC(act.fault_relay === 1'b1, 20, "min_reset")
      // mains loss at speed
      press(0);
      `WAITC(act.normal_relay === 1'b1, 300, "run4")
      sense_in.mains_ok = 1'b0;
      `WAITC(act.generator_mode === 1'b1, 20, "generator")
      `CHK("gen_drive", 1'b0, act.motor_drive)
      `CHK("bearing", 1'b1, act.bearing_power)
      tally_and_finish();
   end
endmodule
bind pump_run_sequencer pump_seq_checker u_chk (.clk_sys(clk_sys), .srst(srst),
   .delay_enable(delay_enable), .vent_fitted(vent_fitted), .op_in(op_in), .sense_in(sense_in),
   .speed(speed), .current(current), .lamps(lamps), .act(act), .fault_code(fault_code));
